// >>> inc/sapc_pkg.sv
// Purpose: Shared constants and types for the slot access permission check
// Assumes: Sixteen slots, 16-bit policy and key words per slot
// Notes: Field positions are bit indices within the per-slot words
package sapc_pkg;

  // Sizing
  localparam int SAPC_SLOTS = 16;
  localparam int SAPC_PTR_W = 4;

  // Per-slot policy word layout
  localparam int POL_UPD_MSB = 15;
  localparam int POL_UPD_LSB = 12;
  localparam int POL_UPKEY_MSB = 11;
  localparam int POL_UPKEY_LSB = 8;
  localparam int POL_SECRET_BIT = 7;
  localparam int POL_CREAD_BIT = 6;
  localparam int POL_RDKEY_MSB = 3;
  localparam int POL_RDKEY_LSB = 0;

  // Bits inside the 4-bit update policy (bit 3 is word bit 15)
  localparam int UPD_MAC_BIT = 3;
  localparam int UPD_CRYPT_BIT = 2;
  localparam int UPD_USE_BIT = 1;
  localparam int UPD_SEL_BIT = 0;

  // Per-slot key word layout
  localparam int KEY_KIND_MSB = 4;
  localparam int KEY_KIND_LSB = 2;
  localparam int KEY_PRIV_BIT = 0;
  localparam logic [2:0] KIND_ECC = 3'h4;
  localparam logic [2:0] KIND_OTHER = 3'h7;

  // Values after reset: secret, reads barred, never writable
  localparam logic [15:0] POLICY_RST = 16'h2080;
  localparam logic [15:0] KEYWORD_RST = 16'h001c;

  // Commands from the command processor
  typedef enum logic [2:0] {
    SAPC_CMD_READ = 3'h0,
    SAPC_CMD_WRITE = 3'h1,
    SAPC_CMD_KEY_DERIVE = 3'h2,
    SAPC_CMD_KEY_GEN = 3'h3,
    SAPC_CMD_PRIV_STORE = 3'h4
  } sapc_cmd_t;

  typedef enum logic [1:0] {
    SAPC_V_ALLOW = 2'h0,
    SAPC_V_DENY = 2'h1,
    SAPC_V_ERROR = 2'h2
  } sapc_verdict_t;

  // One access request, sampled while valid is high
  typedef struct packed {
    sapc_cmd_t cmd;
    logic [SAPC_PTR_W-1:0] slot;
    logic len32;
    logic mac_ok;
    logic cipher_in_ok;
    logic pub_valid;
  } sapc_req_t;

  // Registered answer
  typedef struct packed {
    logic valid;
    logic allow;
    logic deny;
    logic error;
    logic cipher_read;
    logic mac_req;
    logic cipher_in_req;
    logic [SAPC_PTR_W-1:0] key_ptr;
  } sapc_resp_t;

  // Decoded view of one slot
  typedef struct packed {
    logic secret;
    logic cread;
    logic [SAPC_PTR_W-1:0] rd_ptr;
    logic [3:0] upd;
    logic [SAPC_PTR_W-1:0] up_ptr;
    logic [2:0] kind;
    logic ecc;
    logic hash;
    logic priv_key;
  } sapc_view_t;

endpackage : sapc_pkg

// >>> verilog/sapc_slot_view.sv
// Purpose: Split one slot's policy and key words into named fields
// Assumes: Purely combinational, same clock domain as the caller
// Notes: Reserved key kinds decode as neither elliptic-curve nor hash
module sapc_slot_view
  import sapc_pkg::*;
(
  input wire logic [15:0] i_policy_word,
  input wire logic [15:0] i_key_word,
  output sapc_pkg::sapc_view_t o_view
);
  import sapc_pkg::*;

  logic [2:0] kind;

  // Field extraction at the fixed positions
  assign kind = i_key_word[KEY_KIND_MSB:KEY_KIND_LSB];
  assign o_view.secret = i_policy_word[POL_SECRET_BIT];
  assign o_view.cread = i_policy_word[POL_CREAD_BIT];
  assign o_view.rd_ptr = i_policy_word[POL_RDKEY_MSB:POL_RDKEY_LSB];
  assign o_view.upd = i_policy_word[POL_UPD_MSB:POL_UPD_LSB];
  assign o_view.up_ptr = i_policy_word[POL_UPKEY_MSB:POL_UPKEY_LSB];
  assign o_view.kind = kind;

  // Only the two defined codes count; the rest stay unusable
  assign o_view.ecc = (kind == KIND_ECC);
  assign o_view.hash = (kind == KIND_OTHER);
  assign o_view.priv_key = i_key_word[KEY_PRIV_BIT] & (kind == KIND_ECC);

endmodule : sapc_slot_view

// >>> verilog/sapc_top.sv
// Purpose: Decide allow, deny or error for every slot access command
// Assumes: Requests and configuration come from logic on i_clk
// Notes: One verdict per request, registered one cycle after the request
//
// Behaviour
// - Reads of elliptic-curve private key slots are always denied.
// - Secret and ciphered-read both clear: clear reads of 4 or 32 bytes allowed.
// - Secret set, ciphered-read clear: every read denied, slot still holds keys.
// - Both flags set: reads ciphered with read pointer key; 4-byte accesses denied.
// - Update policy all zero lets plain writes of 4 or 32 bytes through.
// - Policy 0001 blocks plain writes while a validated public key is held.
// - Plain writes refused for top bits 00 with bit 13 set, or top bits 10.
// - Policy bit 14 set: plain write needs MAC and ciphered input, 32 bytes.
// - Key derivation refuses targets whose policy bit 13 is clear.
// - Policy bit 12 picks derivation source: own slot or update key pointer.
// - Policy bit 15 set makes key derivation require a valid MAC.
// - Plain write and key derivation refused on private key slots.
// - Key generation or private store on a non-private slot is an error.
// - Key generation allowed on a private slot only with policy bit 13 set.
// - Private store: bit 14 clear is error, else MAC and ciphered input needed.
// - Key generation only on elliptic-curve slots, derivation only on hash slots.
// - Locked secret, read-barred, never-writable slots accept no read or write.
// - Ciphered-read flag is policy bit 6, read pointer is bits 3 to 0.
// - Key kind 100 means elliptic-curve, 111 any other key, rest reserved.
module sapc_top
  import sapc_pkg::*;
#(
  parameter int SLOTS = SAPC_SLOTS
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_cfg_we,
  input wire logic [SAPC_PTR_W-1:0] i_cfg_slot,
  input wire logic [15:0] i_cfg_policy,
  input wire logic [15:0] i_cfg_key,
  input wire logic i_data_locked,
  input wire logic i_req_valid,
  input wire sapc_pkg::sapc_req_t i_req,
  output sapc_pkg::sapc_resp_t o_resp
);
  import sapc_pkg::*;

  logic [15:0] policy_ff [SLOTS];
  logic [15:0] nxt_policy [SLOTS];
  logic [15:0] keyword_ff [SLOTS];
  logic [15:0] nxt_keyword [SLOTS];
  sapc_resp_t resp_ff;
  sapc_resp_t nxt_resp;
  logic slot_ok;
  logic cfg_ok;
  logic [15:0] tgt_policy;
  logic [15:0] tgt_key;
  sapc_view_t view;
  logic never_wr;
  logic sealed;
  logic both_flags;
  sapc_verdict_t verdict;
  logic mac_need;
  logic cin_need;
  logic cread;
  logic [SAPC_PTR_W-1:0] kptr;

  // Slot numbers beyond the fitted storage are caught, not wrapped
  assign slot_ok = (32'(i_req.slot) < SLOTS);
  assign cfg_ok = (32'(i_cfg_slot) < SLOTS);
  assign tgt_policy = slot_ok ? policy_ff[i_req.slot] : POLICY_RST;
  assign tgt_key = slot_ok ? keyword_ff[i_req.slot] : KEYWORD_RST;

  // Configuration store; a load in the request cycle is seen next cycle
  always_comb
  begin
    for (int s = 0; s < SLOTS; s++)
    begin
      nxt_policy[s] = policy_ff[s];
      nxt_keyword[s] = keyword_ff[s];
    end
    if (i_cfg_we && cfg_ok)
    begin
      nxt_policy[i_cfg_slot] = i_cfg_policy;
      nxt_keyword[i_cfg_slot] = i_cfg_key;
    end
  end

  always_ff @(posedge i_clk)
  begin
    for (int s = 0; s < SLOTS; s++)
    begin
      if (i_reset)
      begin
        policy_ff[s] <= POLICY_RST;
        keyword_ff[s] <= KEYWORD_RST;
      end
      else
      begin
        policy_ff[s] <= nxt_policy[s];
        keyword_ff[s] <= nxt_keyword[s];
      end
    end
  end

  // Field view of the addressed slot
  sapc_slot_view u_view (
    .i_policy_word(tgt_policy),
    .i_key_word(tgt_key),
    .o_view(view)
  );

  // Never-writable codes are 001x and 10xx
  assign never_wr = ~view.upd[UPD_CRYPT_BIT] &
                    (view.upd[UPD_MAC_BIT] | view.upd[UPD_USE_BIT]);
  assign sealed = i_data_locked & view.secret & ~view.cread & never_wr;
  assign both_flags = view.secret & view.cread;

  // Verdict; cases are ordered so the strictest bar is tested first
  always_comb
  begin
    verdict = SAPC_V_DENY;
    mac_need = 1'b0;
    cin_need = 1'b0;
    cread = 1'b0;
    kptr = i_req.slot;
    if (!slot_ok)
    begin
      verdict = SAPC_V_ERROR;
    end
    else
    begin
      unique case (i_req.cmd)
        SAPC_CMD_READ:
        begin
          if (view.priv_key)
            verdict = SAPC_V_DENY;
          else if (sealed)
            verdict = SAPC_V_DENY;
          else if (!view.secret && !view.cread)
            verdict = SAPC_V_ALLOW;
          else if (both_flags && i_req.len32)
          begin
            verdict = SAPC_V_ALLOW;
            cread = 1'b1;
            kptr = view.rd_ptr;
          end
          else
            verdict = SAPC_V_DENY;
          // Ciphered-read without secret is misconfigured: refused as unsafe
        end
        SAPC_CMD_WRITE:
        begin
          if (view.priv_key)
            verdict = SAPC_V_DENY;
          else if (sealed)
            verdict = SAPC_V_DENY;
          else if (view.upd[UPD_CRYPT_BIT])
          begin
            mac_need = 1'b1;
            cin_need = 1'b1;
            kptr = view.up_ptr;
            if (i_req.len32 && i_req.mac_ok && i_req.cipher_in_ok)
              verdict = SAPC_V_ALLOW;
          end
          else if (both_flags && !i_req.len32)
            verdict = SAPC_V_DENY;
          else if (never_wr)
            verdict = SAPC_V_DENY;
          else if (view.upd[UPD_SEL_BIT] && i_req.pub_valid)
            verdict = SAPC_V_DENY;
          else
            verdict = SAPC_V_ALLOW;
        end
        SAPC_CMD_KEY_DERIVE:
        begin
          if (view.priv_key)
            verdict = SAPC_V_DENY;
          else if (!view.hash)
            verdict = SAPC_V_DENY;
          else if (!view.upd[UPD_USE_BIT])
            verdict = SAPC_V_DENY;
          else
          begin
            kptr = view.upd[UPD_SEL_BIT] ? view.up_ptr : i_req.slot;
            mac_need = view.upd[UPD_MAC_BIT];
            if (!view.upd[UPD_MAC_BIT] || i_req.mac_ok)
              verdict = SAPC_V_ALLOW;
          end
        end
        SAPC_CMD_KEY_GEN:
        begin
          if (!view.priv_key)
            verdict = SAPC_V_ERROR;
          else if (view.upd[UPD_USE_BIT])
            verdict = SAPC_V_ALLOW;
          else
            verdict = SAPC_V_DENY;
        end
        SAPC_CMD_PRIV_STORE:
        begin
          if (!view.priv_key)
            verdict = SAPC_V_ERROR;
          else if (!view.upd[UPD_CRYPT_BIT])
            verdict = SAPC_V_ERROR;
          else
          begin
            mac_need = 1'b1;
            cin_need = 1'b1;
            kptr = view.up_ptr;
            if (i_req.mac_ok && i_req.cipher_in_ok)
              verdict = SAPC_V_ALLOW;
          end
        end
        default:
        begin
          verdict = SAPC_V_ERROR;
        end
      endcase
    end
  end

  // Answer; only one of allow, deny, error is ever set, so storage can gate on it
  always_comb
  begin
    nxt_resp = '0;
    if (i_req_valid)
    begin
      nxt_resp.valid = 1'b1;
      nxt_resp.allow = (verdict == SAPC_V_ALLOW);
      nxt_resp.deny = (verdict == SAPC_V_DENY);
      nxt_resp.error = (verdict == SAPC_V_ERROR);
      nxt_resp.cipher_read = cread & (verdict == SAPC_V_ALLOW);
      nxt_resp.mac_req = mac_need;
      nxt_resp.cipher_in_req = cin_need;
      nxt_resp.key_ptr = kptr;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      resp_ff <= '0;
    else
      resp_ff <= nxt_resp;
  end

  assign o_resp = resp_ff;

  // Checks on the verdict one cycle after each request
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  chk_priv_read_deny: assert property (
    i_req_valid && slot_ok && i_req.cmd == SAPC_CMD_READ && view.priv_key
    |=> o_resp.valid && o_resp.deny && !o_resp.allow)
    else $error("private key slot read not denied");

  chk_clear_read_ok: assert property (
    i_req_valid && slot_ok && i_req.cmd == SAPC_CMD_READ && !view.priv_key &&
    !view.secret && !view.cread && !sealed
    |=> o_resp.allow && !o_resp.cipher_read)
    else $error("clear read refused");

  chk_secret_read_bar: assert property (
    i_req_valid && slot_ok && i_req.cmd == SAPC_CMD_READ && view.secret && !view.cread
    |=> o_resp.deny)
    else $error("read of secret slot allowed");

  chk_cipher_read_key: assert property (
    i_req_valid && slot_ok && i_req.cmd == SAPC_CMD_READ && both_flags &&
    !view.priv_key && i_req.len32
    |=> o_resp.allow && o_resp.cipher_read && o_resp.key_ptr == $past(tgt_policy[3:0]))
    else $error("ciphered read wrong");

  chk_short_cipher_bar: assert property (
    i_req_valid && slot_ok && both_flags && !i_req.len32 &&
    (i_req.cmd == SAPC_CMD_READ || i_req.cmd == SAPC_CMD_WRITE)
    |=> o_resp.deny)
    else $error("4-byte access to ciphered slot allowed");

  chk_write_always_ok: assert property (
    i_req_valid && slot_ok && i_req.cmd == SAPC_CMD_WRITE && view.upd == 4'h0 &&
    !view.priv_key && !both_flags && !sealed
    |=> o_resp.allow && !o_resp.mac_req)
    else $error("always-writable slot refused");

  chk_pub_lock_write: assert property (
    i_req_valid && slot_ok && i_req.cmd == SAPC_CMD_WRITE && view.upd == 4'h1 &&
    i_req.pub_valid
    |=> o_resp.deny)
    else $error("write to validated public key allowed");

  chk_never_write: assert property (
    i_req_valid && slot_ok && i_req.cmd == SAPC_CMD_WRITE &&
    (view.upd[3:1] == 3'h1 || view.upd[3:2] == 2'h2)
    |=> o_resp.deny)
    else $error("never-writable slot written");

  chk_crypt_write: assert property (
    i_req_valid && slot_ok && i_req.cmd == SAPC_CMD_WRITE && view.upd[UPD_CRYPT_BIT] &&
    !view.priv_key
    |=> o_resp.mac_req && o_resp.cipher_in_req &&
        (o_resp.allow == $past(i_req.len32 && i_req.mac_ok && i_req.cipher_in_ok)))
    else $error("encrypted write decision wrong");

  chk_derive_target: assert property (
    i_req_valid && slot_ok && i_req.cmd == SAPC_CMD_KEY_DERIVE && !view.upd[UPD_USE_BIT]
    |=> o_resp.deny)
    else $error("derivation into barred target allowed");

  chk_derive_source: assert property (
    i_req_valid && slot_ok && i_req.cmd == SAPC_CMD_KEY_DERIVE && view.hash &&
    !view.priv_key && view.upd[UPD_USE_BIT]
    |=> o_resp.key_ptr == ($past(view.upd[0]) ? $past(view.up_ptr) : $past(i_req.slot)))
    else $error("derivation source key wrong");

  chk_derive_mac: assert property (
    i_req_valid && slot_ok && i_req.cmd == SAPC_CMD_KEY_DERIVE && view.hash &&
    !view.priv_key && view.upd[UPD_USE_BIT]
    |=> o_resp.allow == $past(!view.upd[UPD_MAC_BIT] || i_req.mac_ok))
    else $error("derivation MAC gate wrong");

  chk_priv_modify_bar: assert property (
    i_req_valid && slot_ok && view.priv_key &&
    (i_req.cmd == SAPC_CMD_WRITE || i_req.cmd == SAPC_CMD_KEY_DERIVE)
    |=> o_resp.deny)
    else $error("private slot modified by plain command");

  chk_nonpriv_error: assert property (
    i_req_valid && slot_ok && !view.priv_key &&
    (i_req.cmd == SAPC_CMD_KEY_GEN || i_req.cmd == SAPC_CMD_PRIV_STORE)
    |=> o_resp.error)
    else $error("private command on plain slot not an error");

  chk_keygen_gate: assert property (
    o_resp.valid && o_resp.allow && $past(i_req.cmd) == SAPC_CMD_KEY_GEN
    |-> $past(view.upd[UPD_USE_BIT]) && $past(view.priv_key))
    else $error("key generation allowed without bit 13");

  chk_priv_store: assert property (
    i_req_valid && slot_ok && i_req.cmd == SAPC_CMD_PRIV_STORE && view.priv_key
    |=> (o_resp.error != $past(view.upd[UPD_CRYPT_BIT])) &&
        (o_resp.allow == $past(view.upd[2] && i_req.mac_ok && i_req.cipher_in_ok)))
    else $error("private store decision wrong");

  chk_kind_gate: assert property (
    o_resp.valid && o_resp.allow &&
    ($past(i_req.cmd) == SAPC_CMD_KEY_GEN || $past(i_req.cmd) == SAPC_CMD_KEY_DERIVE)
    |-> $past(tgt_key[4:2]) == (($past(i_req.cmd) == SAPC_CMD_KEY_GEN) ? 3'h4 : 3'h7))
    else $error("key kind not honoured");

  chk_sealed_slot: assert property (
    i_req_valid && slot_ok && sealed &&
    (i_req.cmd == SAPC_CMD_READ || i_req.cmd == SAPC_CMD_WRITE)
    |=> o_resp.deny)
    else $error("sealed slot accessed");

  chk_single_verdict: assert property (
    ##1 o_resp.valid == $past(i_req_valid) &&
    (o_resp.valid ? $onehot({o_resp.allow, o_resp.deny, o_resp.error})
                  : !(o_resp.allow || o_resp.deny || o_resp.error)))
    else $error("verdict not single or not timed");

endmodule : sapc_top

// >>> verif/sapc_cfg_agent.sv
// Purpose: Command processor model that loads the slot configuration
// Assumes: Loads begin once reset is low, one slot per cycle
// Notes: The last load aims at slot 14, which a 12-slot design must ignore
module sapc_cfg_agent
  import sapc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  output logic o_cfg_we,
  output logic [SAPC_PTR_W-1:0] o_cfg_slot,
  output logic [15:0] o_cfg_policy,
  output logic [15:0] o_cfg_key,
  output logic o_done
);
  timeunit 1ns;
  timeprecision 1ns;

  // Secret set wherever the update policy is not zero; never ciphered read alone
  localparam logic [15:0] POL [11] = '{16'h0000, 16'h1080, 16'h2080, 16'h8080,
    16'h44c5, 16'hb780, 16'h6080, 16'h0080, 16'h3080, 16'h2080, 16'h0000};
  localparam logic [15:0] KEY [11] = '{16'h001c, 16'h001c, 16'h001c, 16'h001c,
    16'h001c, 16'h001c, 16'h0011, 16'h0011, 16'h001c, 16'h0010, 16'h001c};

  // Loads change just after the falling edge, so the rising edge sees them settled
  initial
  begin
    o_cfg_we = 1'b0;
    o_cfg_slot = '0;
    o_cfg_policy = '0;
    o_cfg_key = '0;
    o_done = 1'b0;
    for (int w = 0; w < 100 && i_reset !== 1'b0; w++) @(posedge i_clk);
    for (int n = 0; n < 11; n++)
    begin
      @(negedge i_clk);
      o_cfg_we = 1'b1;
      o_cfg_slot = (n < 10) ? 4'(n) : 4'he;
      o_cfg_policy = POL[n];
      o_cfg_key = KEY[n];
    end
    @(negedge i_clk);
    o_cfg_we = 1'b0;
    o_done = 1'b1;
  end
endmodule : sapc_cfg_agent

// >>> verif/sapc_top_tb.sv
// Purpose: Self-checking bench for the slot access permission check
// Assumes: Verdict one cycle after each request, design built with 12 slots
// Notes: Expected verdicts come from a shadow of every configuration load to slots 0 to 11
module sapc_top_tb;
  import sapc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int NSLOT = 12;
  logic i_clk = 1'b0;
  logic i_reset;
  logic i_cfg_we;
  logic [3:0] i_cfg_slot;
  logic [15:0] i_cfg_policy;
  logic [15:0] i_cfg_key;
  logic i_data_locked;
  logic i_req_valid;
  sapc_req_t i_req;
  sapc_resp_t o_resp;
  logic cfg_done;
  logic req_seen;
  logic [15:0] pol_sh [16];
  logic [15:0] key_sh [16];
  sapc_resp_t exp_q [$];
  int failures = 0;
  int num_checks = 0;

  always #50 i_clk = ~i_clk;

  sapc_top #(.SLOTS(NSLOT)) sapc_top_inst (.i_clk(i_clk), .i_reset(i_reset),
    .i_cfg_we(i_cfg_we), .i_cfg_slot(i_cfg_slot), .i_cfg_policy(i_cfg_policy),
    .i_cfg_key(i_cfg_key), .i_data_locked(i_data_locked), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_resp(o_resp));
  sapc_cfg_agent sapc_cfg_agent_inst (.i_clk(i_clk), .i_reset(i_reset), .o_cfg_we(i_cfg_we),
    .o_cfg_slot(i_cfg_slot), .o_cfg_policy(i_cfg_policy), .o_cfg_key(i_cfg_key),
    .o_done(cfg_done));

  // Shadow store; a load lands after any request of its own cycle is judged
  always @(posedge i_clk)
  begin
    for (int s = 0; s < 16; s++)
    begin
      if (i_reset)
      begin
        pol_sh[s] <= POLICY_RST;
        key_sh[s] <= KEYWORD_RST;
      end
    end
    if (!i_reset && i_cfg_we && i_cfg_slot < NSLOT)
    begin
      pol_sh[i_cfg_slot] <= i_cfg_policy;
      key_sh[i_cfg_slot] <= i_cfg_key;
    end
    req_seen <= i_req_valid && !i_reset;
  end

  // Reference verdict for one request
  function automatic sapc_resp_t ref_resp(input logic [15:0] p, input logic [15:0] k,
      input sapc_req_t r, input logic lk, input logic inr);
    sapc_resp_t e;
    logic [3:0] u;
    logic priv, never, sealed, ok, err;
    e = '0;
    ok = 1'b0;
    u = p[15:12];
    e.key_ptr = r.slot;
    priv = k[0] && k[4:2] == 3'h4;
    never = u[3:1] == 3'h1 || u[3:2] == 2'h2;
    sealed = lk && p[7] && !p[6] && never;
    case (r.cmd)
      SAPC_CMD_READ:
      begin
        e.cipher_read = !priv && !sealed && p[7] && p[6] && r.len32;
        ok = !priv && !sealed && (e.cipher_read || !p[7] && !p[6]);
        if (e.cipher_read) e.key_ptr = p[3:0];
      end
      SAPC_CMD_WRITE:
      begin
        e.mac_req = !priv && !sealed && u[2];
        e.cipher_in_req = e.mac_req;
        if (e.mac_req) e.key_ptr = p[11:8];
        ok = u[2] ? r.len32 && r.mac_ok && r.cipher_in_ok
            : !(p[7] && p[6] && !r.len32) && !never && !(u == 4'h1 && r.pub_valid);
        ok = ok && !priv && !sealed;
      end
      SAPC_CMD_KEY_DERIVE:
      begin
        ok = !priv && k[4:2] == 3'h7 && u[1];
        if (ok) e.key_ptr = u[0] ? p[11:8] : r.slot;
        e.mac_req = ok && u[3];
        ok = ok && (!u[3] || r.mac_ok);
      end
      SAPC_CMD_KEY_GEN: ok = u[1];
      SAPC_CMD_PRIV_STORE:
      begin
        e.mac_req = priv && u[2];
        e.cipher_in_req = e.mac_req;
        if (e.mac_req) e.key_ptr = p[11:8];
        ok = r.mac_ok && r.cipher_in_ok;
      end
      default: ok = 1'b0;
    endcase
    err = !inr || r.cmd > 3'h4 || r.cmd == SAPC_CMD_PRIV_STORE && !u[2]
        || (r.cmd == SAPC_CMD_KEY_GEN || r.cmd == SAPC_CMD_PRIV_STORE) && !priv;
    e.valid = 1'b1;
    e.error = err;
    e.allow = !err && ok;
    e.deny = !err && !ok;
    return e;
  endfunction : ref_resp

  task automatic end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic check_resp(input sapc_resp_t e, input sapc_resp_t a, input string what);
    num_checks++;
    if (a !== e)
    begin
      failures++;
      $display("mismatch at %0t: %s exp %h got %h", $time, what, e, a);
    end
  endtask : check_resp

  // Issue one request and note its verdict
  task automatic send(input logic [2:0] c, input logic [3:0] s, input logic [3:0] f,
      input logic lk);
    sapc_req_t r;
    @(negedge i_clk);
    r = sapc_req_t'({c, s, f});
    i_req_valid = 1'b1;
    i_req = r;
    i_data_locked = lk;
    exp_q.push_back(ref_resp(pol_sh[s], key_sh[s], r, lk, s < NSLOT));
  endtask : send

  task automatic idle;
    @(negedge i_clk);
    i_req_valid = 1'b0;
  endtask : idle

  // Verdict pulse must follow each request by exactly one cycle, else all zero
  always @(negedge i_clk)
  begin
    if (req_seen === 1'b1)
      check_resp(exp_q.size() > 0 ? exp_q.pop_front() : '0, o_resp, "verdict");
    else
      check_resp('0, o_resp, "idle output");
  end

  initial
  begin
    i_reset = 1'b1;
    i_data_locked = 1'b0;
    i_req_valid = 1'b0;
    i_req = '0;
    void'($urandom(32'h27bda4ba));
    repeat (2) @(negedge i_clk);
    i_reset = 1'b0;
    for (int w = 0; w < 100 && cfg_done !== 1'b1; w++) @(negedge i_clk);
    if (cfg_done !== 1'b1)
    begin
      failures++;
      $display("mismatch at %0t: configuration never finished", $time);
      end_of_test();
    end
    // Every command code on every slot, full and weak authority, back to back
    for (int k = 0; k < 2; k++)
      for (int c = 0; c < 8; c++)
        for (int s = 0; s < 16; s++)
          send(3'(c), 4'(s), k ? 4'h1 : 4'he, k[0]);
    // Random traffic with gaps and lock changes
    repeat (600)
    begin
      if ($urandom % 4 == 0) idle();
      send(3'($urandom % 8), 4'($urandom % 16), 4'($urandom % 16), 1'($urandom % 2));
    end
    // Mid-run reset must bring every slot back to the sealed default
    idle();
    i_reset = 1'b1;
    @(negedge i_clk);
    i_reset = 1'b0;
    for (int c = 0; c < 5; c++)
      for (int s = 0; s < 12; s++)
        send(3'(c), 4'(s), 4'he, 1'b1);
    idle();
    idle();
    if (exp_q.size() != 0)
    begin
      failures++;
      $display("mismatch at %0t: verdicts missing", $time);
    end
    end_of_test();
  end
endmodule : sapc_top_tb
